// ---- dv/two_wire_bus_master_asserts.sv ----
`timescale 1ns/10ps
// ==========================================================================
// port-level checks of the bus master
// ==========================================================================
module two_wire_bus_master_asserts (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    scl_i,
  input wire logic                    scl_oe,
  input wire logic                    sda_i,
  input wire logic                    sda_oe,
  input wire logic                    cmd_valid,
  input wire logic                    cmd_ready,
  input wire two_wire_pkg::cmd_kind_t cmd_kind,
  input wire logic [7:0]              cmd_data,
  input wire logic                    cmd_last,
  input wire logic                    done,
  input wire logic                    ack_seen,
  input wire logic                    cmd_err,
  input wire logic                    arb_lost,
  input wire logic                    bus_busy
);
  import two_wire_pkg::*;
  cmd_kind_t   kind_ff;
  logic        last_ff, held_ff, first_ff, take;
  logic [10:0] low_ff, high_ff;
  assign take = cmd_valid && cmd_ready;
  wire held = done ? kind_ff != cmd_stop : held_ff;
  always_ff @(posedge clk) begin
    if (take) begin
      kind_ff <= cmd_kind;
      last_ff <= cmd_last;
    end
  end
  // the bus is ours from a finished start until a finished stop or a loss
  always_ff @(posedge clk) begin
    if (sys_rst || arb_lost) begin
      held_ff  <= 1'b0;
      first_ff <= 1'b0;
    end else if (done) begin
      held_ff  <= kind_ff != cmd_stop;
      first_ff <= kind_ff == cmd_start;
    end
  end
  // saturating runs: our own low drive, and the real high level of the line
  always_ff @(posedge clk) begin
    low_ff  <= (sys_rst || !scl_oe) ? 11'h0 : low_ff + {10'h0, low_ff != 11'h7ff};
    high_ff <= (sys_rst || scl_oe || !scl_i) ? 11'h0 : high_ff + {10'h0, high_ff != 11'h7ff};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_busy: assert property (scl_i && $fell(sda_i) |-> ##[1:24] bus_busy)
    else $error("start on the lines not flagged busy");
  a_stop_free: assert property (scl_i && $rose(sda_i) |-> ##[1:24] !bus_busy)
    else $error("stop on the lines did not free the bus");
  a_idle_refuse: assert property (take && !held && cmd_kind != cmd_start |=> cmd_err)
    else $error("command without a held bus was accepted");
  a_first_refuse: assert property (take && first_ff && cmd_kind inside {cmd_read, cmd_stop} |=> cmd_err)
    else $error("read or stop right after start was accepted");
  a_addr_refuse: assert property (take && first_ff && cmd_kind == cmd_write &&
    (cmd_data == BCAST_READ || cmd_data[7:4] == RESERVED_HI) |=> cmd_err) else $error("barred address accepted");
  a_err_quiet: assert property (cmd_err |-> $stable(scl_oe) && $stable(sda_oe))
    else $error("refused command moved the lines");
  a_read_nack: assert property (done && kind_ff == cmd_read |-> ack_seen == !last_ff)
    else $error("read answer slot wrong");
  a_low_min: assert property ($fell(scl_oe) && !arb_lost |-> low_ff >= {1'b0, T_LOW})
    else $error("clock low phase too short");
  a_high_min: assert property ($rose(scl_oe) |-> high_ff >= {1'b0, T_HIGH})
    else $error("clock high phase counted before the line rose");
  a_sda_stop: assert property ($fell(sda_oe) && !scl_oe && scl_i && !arb_lost |-> ##[1:24] !bus_busy)
    else $error("data moved while clock high outside a stop");
  c_read_done: cover property (done && kind_ff == cmd_read && !last_ff);
  c_refused: cover property (cmd_err);
  c_stop_done: cover property (done && kind_ff == cmd_stop);
endmodule // two_wire_bus_master_asserts

// ---- dv/two_wire_bus_master_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module two_wire_bus_master_tb;
  import two_wire_pkg::*;
  logic       clk, sys_rst, cmd_valid, cmd_last, rd_ready, cmd_ready, done, ack_seen;
  logic       scl_oe, sda_oe, s_scl_oe, s_sda_oe, cmd_err, bus_busy, rd_valid, arb_lost;
  cmd_kind_t  cmd_kind;
  logic [7:0] cmd_data, rd_data, rx_byte;
  int         n_fail, cmp_count;
  wire        scl = !(scl_oe || s_scl_oe);
  wire        sda = !(sda_oe || s_sda_oe);
  initial clk = 1'b0;
  always #4 clk = !clk;
  two_wire_bus_master two_wire_bus_master_i (
    .clk(clk), .sys_rst(sys_rst), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .done(done), .ack_seen(ack_seen), .cmd_err(cmd_err),
    .arb_lost(arb_lost), .bus_busy(bus_busy), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  two_wire_slave_model two_wire_slave_model_i (
    .scl(scl), .sda(sda), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .rx_byte(rx_byte));
  // ==========================================================================
  // one command: held until taken, then wait for its end
  // ==========================================================================
  task automatic op(input cmd_kind_t k, input logic [7:0] d, input logic l, input logic err);
    int n;
    {cmd_kind, cmd_data, cmd_last, cmd_valid} = {k, d, l, 1'b1};
    n = 0;
    while (cmd_ready !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && cmd_err !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    `CHK({done, cmd_err, arb_lost}, {!err, err, 1'b0})
  endtask
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_nack();
    op(cmd_start, 8'h00, 1'b0, 1'b0);
    `CHK(bus_busy, 1'b1)
    op(cmd_write, 8'h50, 1'b0, 1'b0);
    `CHK(ack_seen, 1'b0)
    op(cmd_write, 8'h11, 1'b0, 1'b1);
    op(cmd_start, 8'h00, 1'b0, 1'b0);
    `CHK(bus_busy, 1'b1)
  endtask
  task automatic t_write();
    op(cmd_stop, 8'h00, 1'b0, 1'b1);
    op(cmd_read, 8'h00, 1'b0, 1'b1);
    op(cmd_write, BCAST_READ, 1'b0, 1'b1);
    op(cmd_write, 8'hf4, 1'b0, 1'b1);
    op(cmd_write, 8'h00, 1'b0, 1'b0);
    `CHK(ack_seen, 1'b1)
    op(cmd_write, 8'hc3, 1'b0, 1'b0);
    `CHK(ack_seen, 1'b1)
    `CHK(rx_byte, 8'hc3)
    op(cmd_read, 8'h00, 1'b0, 1'b1);
    op(cmd_stop, 8'h00, 1'b0, 1'b0);
    `CHK(bus_busy, 1'b0)
    op(cmd_write, 8'hc3, 1'b0, 1'b1);
  endtask
  task automatic t_read();
    logic [7:0] want [2];
    want = '{8'h96, 8'hcd};
    op(cmd_start, 8'h00, 1'b0, 1'b0);
    op(cmd_write, 8'h55, 1'b0, 1'b0);
    `CHK(ack_seen, 1'b1)
    op(cmd_write, 8'h12, 1'b0, 1'b1);
    op(cmd_read, 8'h00, 1'b0, 1'b0);
    `CHK(ack_seen, 1'b1)
    op(cmd_read, 8'h00, 1'b1, 1'b0);
    `CHK(ack_seen, 1'b0)
    // both entries taken while we stall, so no further command may enter
    repeat (3) @(negedge clk);
    `CHK(cmd_ready, 1'b0)
    for (int i = 0; i < 2; i++) begin
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, want[i])
      rd_ready = 1'b1;
      @(negedge clk);
      rd_ready = 1'b0;
    end
    `CHK(rd_valid, 1'b0)
    op(cmd_stop, 8'h00, 1'b0, 1'b0);
  endtask
  initial begin
    {n_fail, cmp_count} = 64'h0;
    {sys_rst, cmd_valid, cmd_last, rd_ready, cmd_data, cmd_kind} = {4'b1000, 8'h00, cmd_start};
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_nack();
    t_write();
    t_read();
    conclude();
  end
  // scenarios take about 80000 cycles
  initial begin
    repeat (98000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule // two_wire_bus_master_tb
bind two_wire_bus_master two_wire_bus_master_asserts two_wire_bus_master_asserts_i (
  .clk(clk), .sys_rst(sys_rst), .scl_i(scl_i), .scl_oe(scl_oe), .sda_i(sda_i), .sda_oe(sda_oe),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
  .cmd_last(cmd_last), .done(done), .ack_seen(ack_seen), .cmd_err(cmd_err), .arb_lost(arb_lost),
  .bus_busy(bus_busy));

// ---- dv/two_wire_slave_model.sv ----
`timescale 1ns/10ps
// ==========================================================================
// behavioural slave; released lines float high through the pull-ups
// ==========================================================================
module two_wire_slave_model #(
  parameter logic [6:0] OWN_ADDR   = 7'h2a,
  parameter int         STRETCH_NS = 6000
) (
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       scl_oe,
  output logic       sda_oe,
  output logic [7:0] rx_byte
);
  logic [7:0] sh, tx;
  logic [3:0] cnt;
  logic       act, adr, sel, rd, mack;
  initial begin
    {act, adr, sel, rd, mack, scl_oe, sda_oe} = 7'h0;
    {sh, tx, rx_byte, cnt} = 28'h0;
  end
  always @(negedge sda) if (scl) begin
    {act, adr, sel, cnt, tx} = {3'b110, 4'h0, 8'h96};
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sel = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    else mack = !sda;
    cnt = cnt + 4'h1;
  end
  // data only moves while the clock is low, so no start or stop of our own
  always @(negedge scl) if (act) begin
    sda_oe = 1'b0;
    if (cnt == 4'h8) begin
      if (adr) begin
        sel = sh[7:1] == OWN_ADDR || sh == 8'h00;
        rd  = sh[0];
      end
      sda_oe = sel && (adr || !rd);
      if (sel && !adr && !rd) rx_byte = sh;
    end else if (cnt == 4'h9) begin
      if (sel && rd && !adr) begin
        if (mack) tx = tx + 8'h37;
        else sel = 1'b0;
      end
      {adr, cnt} = 5'h0;
      sda_oe = sel && rd && !tx[7];
      if (sel) begin
        scl_oe = 1'b1;
        #(STRETCH_NS) scl_oe = 1'b0;
      end
    end else if (sel && rd && !adr) begin
      sda_oe = !tx[3'd7 - cnt[2:0]];
    end
  end
endmodule // two_wire_slave_model

// ---- include/two_wire_pkg.sv ----
// ==========================================================================
// shared constants for the two-wire bus master
// ==========================================================================
package two_wire_pkg;

  // ========================================================================
  // timing, all least times, rounded up to whole clocks
  // ========================================================================
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_LOW_NS    = 5000;
  localparam int SCL_HIGH_NS   = 5000;
  localparam int START_HOLD_NS = 4000;
  localparam int BUS_FREE_NS   = 4700;
  localparam int SPIKE_NS      = 50;

  localparam int SCL_LOW_CYC    = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HIGH_CYC   = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FREE_CYC   = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] T_LOW      = TMR_W'(SCL_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] T_LOW_HALF = TMR_W'(SCL_LOW_CYC / 2);
  localparam logic [TMR_W-1:0] T_HIGH     = TMR_W'(SCL_HIGH_CYC - 1);
  localparam logic [TMR_W-1:0] T_HOLD     = TMR_W'(START_HOLD_CYC - 1);
  localparam logic [TMR_W-1:0] T_FREE     = TMR_W'(BUS_FREE_CYC - 1);

  // ========================================================================
  // packet layout
  // ========================================================================
  localparam logic [3:0] ACK_BIT_IDX  = 4'h8;
  localparam logic [7:0] BCAST_READ   = 8'h01;
  localparam logic [3:0] RESERVED_HI  = 4'hf;
  localparam logic [1:0] PKT_SAT      = 2'h2;

  typedef enum logic [1:0] {
    cmd_start,
    cmd_write,
    cmd_read,
    cmd_stop
  } cmd_kind_t;

endpackage

// ---- verilog/line_filter.sv ----
`timescale 1ns/10ps
// ==========================================================================
// two-flop synchroniser plus spike rejection for one bus line
// ==========================================================================
module line_filter #(
  parameter int FILT_CYC = 7
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic line_in,
  output logic      line_out
);
  logic       sync1_ff;
  logic       sync2_ff;
  logic       out_ff;
  logic [7:0] cnt_ff;
  wire        differs = sync2_ff != out_ff;
  wire        settled = cnt_ff == 8'(FILT_CYC - 1);

  always_ff @(posedge clk) begin
    sync1_ff <= line_in;
    sync2_ff <= sync1_ff;
  end

  // the line must hold its new level for FILT_CYC clocks before we follow it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_ff <= 1'b1;
      cnt_ff <= 8'h00;
    end else if (differs && settled) begin
      out_ff <= sync2_ff;
      cnt_ff <= 8'h00;
    end else if (differs) begin
      cnt_ff <= cnt_ff + 8'h01;
    end else begin
      cnt_ff <= 8'h00;
    end
  end

  assign line_out = out_ff;
endmodule // line_filter

// ---- verilog/pair_buffer.sv ----
`timescale 1ns/10ps
// ==========================================================================
// two-entry buffer, entry 0 is always the head
// ==========================================================================
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_ff [2];
  logic [1:0]       vld_ff;
  wire              push = in_valid && !vld_ff[1];
  wire              pop  = out_ready && vld_ff[0];
  wire              to_head = !vld_ff[0] || (pop && !vld_ff[1]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vld_ff <= 2'h0;
    end else begin
      vld_ff[0] <= push || vld_ff[1] || (vld_ff[0] && !pop);
      vld_ff[1] <= (push && vld_ff[0] && !pop) || (vld_ff[1] && !pop);
    end
  end

  always_ff @(posedge clk) begin
    if (pop && vld_ff[1]) begin
      mem_ff[0] <= mem_ff[1];
    end else if (push && to_head) begin
      mem_ff[0] <= in_data;
    end
    if (push && !to_head) begin
      mem_ff[1] <= in_data;
    end
  end

  assign in_ready  = !vld_ff[1];
  assign out_valid = vld_ff[0];
  assign out_data  = mem_ff[0];
endmodule // pair_buffer

// ---- verilog/two_wire_bus_master.sv ----
`timescale 1ns/10ps
// Function
// - keep SDA steady while SCL is high, except start and stop.
// - start is SDA falling with SCL high; stop is SDA rising with SCL high.
// - bus busy from start until stop; never start while busy.
// - repeated start keeps the bus until the next stop.
// - address packet is seven address bits, direction bit, acknowledge slot.
// - direction one reads from the slave, zero writes to it.
// - after an unacknowledged address send stop or repeated start.
// - addresses and data go out most significant bit first.
// - never send the broadcast address with the read bit.
// - addresses with upper four bits all ones are reserved.
// - data packet is eight bits and an acknowledge slot from the receiver.
// - receiver answers its final byte with not-acknowledge.
// - only the master clocks SCL and makes start and stop.
// - transfer needs address and data; start then stop is illegal.
// - slave may stretch SCL low; master waits for SCL to rise.
// - contending masters use identical packet sequences.
// - slave clock runs at least 16 times the bus clock.
module two_wire_bus_master (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    scl_i,
  output logic                         scl_o,
  output logic                         scl_oe,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire two_wire_pkg::cmd_kind_t cmd_kind,
  input  wire logic [7:0]              cmd_data,
  input  wire logic                    cmd_last,
  output logic                         done,
  output logic                         ack_seen,
  output logic                         cmd_err,
  output logic                         arb_lost,
  output logic                         bus_busy,
  output logic                         rd_valid,
  input  wire logic                    rd_ready,
  output logic [7:0]                   rd_data
);
  import two_wire_pkg::*;

  typedef enum logic [3:0] {
    st_idle,
    st_hold,
    st_rs_low,
    st_st_high,
    st_st_hold,
    st_bit_low,
    st_bit_high,
    st_sp_low,
    st_sp_high,
    st_sp_free
  } state_t;

  // ==========================================================================
  // input conditioning
  // ==========================================================================
  wire [1:0] raw_lines = {sda_i, scl_i};
  wire [1:0] flt_lines;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      line_filter #(
        .FILT_CYC (SPIKE_CYC)
      ) u_filt (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .line_in  (raw_lines[gi]),
        .line_out (flt_lines[gi])
      );
    end
  endgenerate

  wire scl_f = flt_lines[0];
  wire sda_f = flt_lines[1];

  // ==========================================================================
  // state
  // ==========================================================================
  state_t           state_ff;
  state_t           nxt_state;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] nxt_tmr;
  logic [7:0]       shift_ff;
  logic [7:0]       nxt_shift;
  logic [3:0]       bit_ff;
  logic [3:0]       nxt_bit;
  logic [1:0]       pkt_ff;
  logic [1:0]       nxt_pkt;
  logic             rd_mode_ff;
  logic             nxt_rd_mode;
  logic             last_ff;
  logic             nxt_last;
  logic             dir_ff;
  logic             nxt_dir;
  logic             nack_ff;
  logic             nxt_nack;
  logic             rise_ff;
  logic             nxt_rise;
  logic             ackbit_ff;
  logic             nxt_ackbit;
  logic             scl_oe_ff;
  logic             nxt_scl_oe;
  logic             sda_oe_ff;
  logic             nxt_sda_oe;
  logic             done_ff;
  logic             nxt_done;
  logic             ack_seen_ff;
  logic             nxt_ack_seen;
  logic             err_ff;
  logic             nxt_err;
  logic             arb_ff;
  logic             nxt_arb;
  logic             push_ff;
  logic             nxt_push;
  logic             cmd_ready_ff;
  logic             busy_ff;
  logic             scl_q_ff;
  logic             sda_q_ff;
  logic             zero_ff;
  logic             buf_room;

  // ==========================================================================
  // decode
  // ==========================================================================
  wire take       = cmd_valid && cmd_ready_ff;
  wire tdone      = tmr_ff == '0;
  wire [TMR_W-1:0] tmr_dec = tdone ? tmr_ff : tmr_ff - 1'b1;
  wire is_ack_bit = bit_ff == ACK_BIT_IDX;
  wire first_pkt  = pkt_ff == 2'h0;
  // a broadcast read would let several slaves answer at once
  wire bad_addr   = cmd_data == BCAST_READ || cmd_data[7:4] == RESERVED_HI;
  wire wr_refused = first_pkt ? bad_addr : (nack_ff || dir_ff);
  wire rd_refused = first_pkt || nack_ff || !dir_ff;
  wire sp_refused = pkt_ff != PKT_SAT && !nack_ff;
  // data bits go out from bit 7 down; the ack slot is driven only when reading
  wire drive_bit  = is_ack_bit ? (rd_mode_ff && !last_ff) : (!rd_mode_ff && !shift_ff[7]);
  wire own_bit    = is_ack_bit ? rd_mode_ff : !rd_mode_ff;
  wire lost_now   = own_bit && !sda_oe_ff && !sda_f;
  wire start_seen = scl_f && scl_q_ff && sda_q_ff && !sda_f;
  wire stop_seen  = scl_f && scl_q_ff && !sda_q_ff && sda_f;
  wire ready_next = (nxt_state == st_idle || nxt_state == st_hold) && buf_room && !push_ff && !nxt_push;

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_comb begin
    nxt_state    = state_ff;
    nxt_tmr      = tmr_dec;
    nxt_shift    = shift_ff;
    nxt_bit      = bit_ff;
    nxt_pkt      = pkt_ff;
    nxt_rd_mode  = rd_mode_ff;
    nxt_last     = last_ff;
    nxt_dir      = dir_ff;
    nxt_nack     = nack_ff;
    nxt_rise     = rise_ff;
    nxt_ackbit   = ackbit_ff;
    nxt_scl_oe   = scl_oe_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_done     = 1'b0;
    nxt_ack_seen = ack_seen_ff;
    nxt_err      = 1'b0;
    nxt_arb      = 1'b0;
    nxt_push     = 1'b0;
    case (state_ff)
      st_idle: begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        if (take) begin
          if (cmd_kind != cmd_start || busy_ff) begin
            nxt_err = 1'b1;
          end else begin
            nxt_state = st_st_high;
            nxt_tmr   = T_FREE;
          end
        end
      end
      st_hold: begin
        if (take) begin
          case (cmd_kind)
            cmd_start: begin
              // release SDA while SCL is still low, then rise for the new start
              nxt_state  = st_rs_low;
              nxt_sda_oe = 1'b0;
              nxt_tmr    = T_LOW;
            end
            cmd_write: begin
              if (wr_refused) begin
                nxt_err = 1'b1;
              end else begin
                nxt_state   = st_bit_low;
                nxt_tmr     = T_LOW;
                nxt_shift   = cmd_data;
                nxt_rd_mode = 1'b0;
                nxt_bit     = 4'h0;
                if (first_pkt) begin
                  nxt_dir = cmd_data[0];
                end
              end
            end
            cmd_read: begin
              if (rd_refused) begin
                nxt_err = 1'b1;
              end else begin
                nxt_state   = st_bit_low;
                nxt_tmr     = T_LOW;
                nxt_rd_mode = 1'b1;
                nxt_last    = cmd_last;
                nxt_bit     = 4'h0;
              end
            end
            default: begin
              if (sp_refused) begin
                nxt_err = 1'b1;
              end else begin
                nxt_state  = st_sp_low;
                nxt_tmr    = T_LOW;
                nxt_sda_oe = 1'b1;
              end
            end
          endcase
        end
      end
      st_rs_low: begin
        if (tdone) begin
          nxt_scl_oe = 1'b0;
          nxt_state  = st_st_high;
          nxt_tmr    = T_FREE;
        end
      end
      st_st_high: begin
        if (!scl_f) begin
          nxt_tmr = T_FREE;
        end else if (tdone && !sda_f) begin
          // someone else started first: back off without touching the lines
          nxt_state = st_idle;
          nxt_arb   = 1'b1;
        end else if (tdone) begin
          nxt_sda_oe = 1'b1;
          nxt_state  = st_st_hold;
          nxt_tmr    = T_HOLD;
        end
      end
      st_st_hold: begin
        if (tdone) begin
          nxt_scl_oe = 1'b1;
          nxt_state  = st_hold;
          nxt_pkt    = 2'h0;
          nxt_nack   = 1'b0;
          nxt_done   = 1'b1;
        end
      end
      st_bit_low: begin
        // SDA only moves in the middle of the low phase, never near an edge
        if (tmr_ff == T_LOW_HALF) begin
          nxt_sda_oe = drive_bit;
        end
        if (tdone) begin
          nxt_scl_oe = 1'b0;
          nxt_rise   = 1'b0;
          nxt_state  = st_bit_high;
          nxt_tmr    = T_HIGH;
        end
      end
      st_bit_high: begin
        if (!rise_ff) begin
          nxt_tmr = T_HIGH;
          if (scl_f) begin
            nxt_rise = 1'b1;
            if (is_ack_bit) begin
              nxt_ackbit = !sda_f;
            end else begin
              nxt_shift = {shift_ff[6:0], sda_f};
            end
            if (lost_now) begin
              // give both lines up at once; the winner carries on alone
              nxt_scl_oe = 1'b0;
              nxt_sda_oe = 1'b0;
              nxt_state  = st_idle;
              nxt_arb    = 1'b1;
            end
          end
        end else if (!scl_f || tdone) begin
          // a shorter high phase elsewhere ends ours too
          nxt_scl_oe = 1'b1;
          if (is_ack_bit) begin
            nxt_state    = st_hold;
            nxt_done     = 1'b1;
            nxt_ack_seen = ackbit_ff;
            nxt_push     = rd_mode_ff;
            nxt_pkt      = (pkt_ff == PKT_SAT) ? pkt_ff : pkt_ff + 2'h1;
            if (first_pkt) begin
              nxt_nack = !ackbit_ff;
            end
          end else begin
            nxt_bit   = bit_ff + 4'h1;
            nxt_state = st_bit_low;
            nxt_tmr   = T_LOW;
          end
        end
      end
      st_sp_low: begin
        if (tdone) begin
          nxt_scl_oe = 1'b0;
          nxt_state  = st_sp_high;
          nxt_tmr    = T_HIGH;
        end
      end
      st_sp_high: begin
        if (!scl_f) begin
          nxt_tmr = T_HIGH;
        end else if (tdone) begin
          nxt_sda_oe = 1'b0;
          nxt_state  = st_sp_free;
          nxt_tmr    = T_FREE;
        end
      end
      st_sp_free: begin
        if (tdone) begin
          nxt_state = st_idle;
          nxt_done  = 1'b1;
        end
      end
      default: begin
        nxt_state  = st_idle;
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff   <= st_idle;
      tmr_ff     <= '0;
      bit_ff     <= 4'h0;
      pkt_ff     <= 2'h0;
      rd_mode_ff <= 1'b0;
      last_ff    <= 1'b0;
      dir_ff     <= 1'b0;
      nack_ff    <= 1'b0;
      rise_ff    <= 1'b0;
      ackbit_ff  <= 1'b0;
      shift_ff   <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      tmr_ff     <= nxt_tmr;
      bit_ff     <= nxt_bit;
      pkt_ff     <= nxt_pkt;
      rd_mode_ff <= nxt_rd_mode;
      last_ff    <= nxt_last;
      dir_ff     <= nxt_dir;
      nack_ff    <= nxt_nack;
      rise_ff    <= nxt_rise;
      ackbit_ff  <= nxt_ackbit;
      shift_ff   <= nxt_shift;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
      done_ff      <= 1'b0;
      ack_seen_ff  <= 1'b0;
      err_ff       <= 1'b0;
      arb_ff       <= 1'b0;
      push_ff      <= 1'b0;
      cmd_ready_ff <= 1'b0;
      zero_ff      <= 1'b0;
    end else begin
      scl_oe_ff    <= nxt_scl_oe;
      sda_oe_ff    <= nxt_sda_oe;
      done_ff      <= nxt_done;
      ack_seen_ff  <= nxt_ack_seen;
      err_ff       <= nxt_err;
      arb_ff       <= nxt_arb;
      push_ff      <= nxt_push;
      cmd_ready_ff <= ready_next;
      zero_ff      <= 1'b0;
    end
  end

  // bus busy is tracked from the lines, so starts by other masters count too
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_ff  <= 1'b0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_f;
      sda_q_ff <= sda_f;
      if (start_seen) begin
        busy_ff <= 1'b1;
      end else if (stop_seen) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // read data path; a full buffer holds cmd_ready low so no byte is lost
  // ==========================================================================
  pair_buffer #(
    .WIDTH (8)
  ) u_rdbuf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_ff),
    .in_ready  (buf_room),
    .in_data   (shift_ff),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign scl_o     = zero_ff;
  assign sda_o     = zero_ff;
  assign scl_oe    = scl_oe_ff;
  assign sda_oe    = sda_oe_ff;
  assign cmd_ready = cmd_ready_ff;
  assign done      = done_ff;
  assign ack_seen  = ack_seen_ff;
  assign cmd_err   = err_ff;
  assign arb_lost  = arb_ff;
  assign bus_busy  = busy_ff;
endmodule // two_wire_bus_master
